// [hdl/tsc_pkg.sv]
// Package: constants and types for the two-state controller mode logic
package tsc_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CFG = 12'h000;
  localparam logic [11:0] OFS_SP1 = 12'h004;
  localparam logic [11:0] OFS_SP2 = 12'h008;
  localparam logic [11:0] OFS_SPLO = 12'h00C;
  localparam logic [11:0] OFS_SPHI = 12'h010;
  localparam logic [11:0] OFS_YLVL = 12'h014;
  localparam logic [11:0] OFS_CTRL = 12'h018;
  localparam logic [11:0] OFS_CYC = 12'h01C;
  localparam logic [11:0] OFS_STAT = 12'h020;
  localparam logic [11:0] OFS_PV = 12'h024;
  // ---------------------------------------------------------------
  // Fields and values (tenths for values, percent for levels)
  // ---------------------------------------------------------------
  localparam int CFG_W = 24;
  localparam logic signed [17:0] SP_MIN = -18'sd19990;
  localparam logic signed [17:0] SP_MAX = 18'sd99990;
  localparam logic [6:0] PCT_MAX = 7'd100;
  localparam logic [6:0] PCT_DEF = 7'd0;
  localparam logic [15:0] CYC_DEF = 16'd20;
  localparam logic [15:0] CYC_RELAY = 16'd20;
  localparam logic [15:0] CYC_LOGIC = 16'd5;
  localparam logic [2:0] SEL_NONE = 3'd0;
  localparam logic [31:0] CFG_RST = 32'h0000_0151;

  typedef enum logic [1:0] {FN_OFF = 2'd0, FN_THERMO = 2'd1, FN_TWO_STATE = 2'd2}
    tsc_func_t;

  typedef struct packed {
    logic [2:0] sel_tune_inh;
    logic [2:0] sel_tune_ss;
    logic [2:0] sel_lock;
    logic [2:0] sel_man;
    logic [2:0] sel_sp;
    logic accept_cyc;
    logic out_logic;
    logic tune_allow;
    logic y_err_hold;
    logic y_man_hold;
    logic man_disable;
    logic dir_direct;
    logic [1:0] func;
  } tsc_cfg_t;
endpackage

// [hdl/tsc_sel.sv]
// Digital input selector: synchronise inputs and pick one per function
`timescale 1ns/10ps
module tsc_sel
  import tsc_pkg::*;
#(
  parameter int N_DI = 7
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N_DI-1:0] di,
  input wire logic [2:0] sel,
  output logic level,
  output logic assigned
);
  logic [N_DI-1:0] s1_r;
  logic [N_DI-1:0] s2_r;

  // Two-stage synchroniser on raw pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= di;
      s2_r <= s1_r;
    end
  end

  // Unselected function stays inactive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level <= 1'b0;
      assigned <= 1'b0;
    end
    else
    begin
      assigned <= (sel != SEL_NONE) && (int'(sel) <= N_DI);
      level <= (sel != SEL_NONE) && (int'(sel) <= N_DI) && s2_r[sel - 3'd1];
    end
  end
endmodule // tsc_sel

// [hdl/tsc_mode.sv]
// Top: mode, setpoint, output level and autotuning control
// Notes on behaviour
// - Function is off, thermostat or two-state controller; behaviour follows it.
// - Inverse direction: output positive when actual below setpoint (heating).
// - Direct direction: output positive when actual above setpoint (cooling).
// - Setpoints span -1999.0..9999.0, default 0, clamped to limit registers.
// - Assigned changeover input high selects setpoint 2, else setpoint 1.
// - Manual enabled by default; keys or assigned signal may enter manual.
// - Manual disabled refuses every manual entry request.
// - Assigned manual/auto input high means manual, low means automatic.
// - Manual lock input high inhibits entry into manual mode.
// - Manual entry holds previous level or applies configured manual level.
// - Manual level is 0..100 percent, default 0.
// - Measurement fault drives held level or replacement level (default).
// - Replacement level is 0..100 percent, default 0.
// - Autotuning lock setting permits or fully prevents autotuning.
// - Output type relay or logic sets autotuned cycle time basis.
// - At tuning end, accept determined cycle time only if setting on.
// - Rising start/stop edge toggles tuning; levels and falling edges ignored.
// - Autotuning inhibit input high prevents autotuning.
// - Each signal function comes from a selected input; none means inactive.
`timescale 1ns/10ps
module tsc_mode
  import tsc_pkg::*;
#(
  parameter int N_DI = 7
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_DI-1:0] di,
  input wire logic signed [17:0] actual,
  input wire logic meas_fault,
  input wire logic signed [7:0] pid_level,
  input wire logic tune_done,
  input wire logic [15:0] tune_cyc,
  output logic signed [7:0] y_out,
  output logic out_on,
  output logic tune_run,
  output logic manual,
  output logic sp2_active,
  output logic signed [17:0] sp_active
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  tsc_cfg_t cfg_r;
  logic signed [17:0] sp1_r;
  logic signed [17:0] sp2_r;
  logic signed [17:0] splo_r;
  logic signed [17:0] sphi_r;
  logic [6:0] yman_r;
  logic [6:0] yrep_r;
  logic [15:0] cyc_r;
  logic key_man_r;
  logic man_nxt;
  logic signed [7:0] y_hold_r;
  logic signed [7:0] y_nxt;
  logic fault_d_r;
  logic man_d_r;
  logic ss_d_r;
  logic wr;
  logic rd;
  logic signed [17:0] sp_sel;
  logic signed [17:0] sp_nxt;
  logic sp_lv;
  logic sp_as;
  logic man_lv;
  logic man_as;
  logic lock_lv;
  logic ss_lv;
  logic inh_lv;
  logic tune_ok;
  logic map_hit;

  // ---------------------------------------------------------------
  // Input selectors
  // ---------------------------------------------------------------
  tsc_sel #(.N_DI(N_DI)) u_sp (.pclk(pclk), .presetn(presetn), .di(di),
    .sel(cfg_r.sel_sp), .level(sp_lv), .assigned(sp_as));
  tsc_sel #(.N_DI(N_DI)) u_man (.pclk(pclk), .presetn(presetn), .di(di),
    .sel(cfg_r.sel_man), .level(man_lv), .assigned(man_as));
  tsc_sel #(.N_DI(N_DI)) u_lock (.pclk(pclk), .presetn(presetn), .di(di),
    .sel(cfg_r.sel_lock), .level(lock_lv), .assigned());
  tsc_sel #(.N_DI(N_DI)) u_ss (.pclk(pclk), .presetn(presetn), .di(di),
    .sel(cfg_r.sel_tune_ss), .level(ss_lv), .assigned());
  tsc_sel #(.N_DI(N_DI)) u_inh (.pclk(pclk), .presetn(presetn), .di(di),
    .sel(cfg_r.sel_tune_inh), .level(inh_lv), .assigned());

  // ---------------------------------------------------------------
  // APB slave, zero wait states
  // ---------------------------------------------------------------
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign map_hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_PV);

  function automatic logic signed [17:0] clamp_val(input logic [31:0] v);
    logic signed [17:0] s;
    s = v[17:0];
    if (s < SP_MIN)
      clamp_val = SP_MIN;
    else if (s > SP_MAX)
      clamp_val = SP_MAX;
    else
      clamp_val = s;
  endfunction

  function automatic logic [6:0] pct(input logic [6:0] v);
    pct = (v > PCT_MAX) ? PCT_MAX : v;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r <= tsc_cfg_t'(CFG_RST[CFG_W-1:0]);
      sp1_r <= '0;
      sp2_r <= '0;
      splo_r <= SP_MIN;
      sphi_r <= SP_MAX;
      yman_r <= PCT_DEF;
      yrep_r <= PCT_DEF;
      key_man_r <= 1'b0;
    end
    else if (wr && map_hit)
    begin
      unique case (paddr)
        OFS_CFG: cfg_r <= tsc_cfg_t'(pwdata[CFG_W-1:0]);
        OFS_SP1: sp1_r <= clamp_val(pwdata);
        OFS_SP2: sp2_r <= clamp_val(pwdata);
        OFS_SPLO: splo_r <= clamp_val(pwdata);
        OFS_SPHI: sphi_r <= clamp_val(pwdata);
        OFS_YLVL:
        begin
          yman_r <= pct(pwdata[6:0]);
          yrep_r <= pct(pwdata[14:8]);
        end
        OFS_CTRL: key_man_r <= pwdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (rd)
    begin
      unique case (paddr)
        OFS_CFG: prdata <= {{(32-CFG_W){1'b0}}, cfg_r};
        OFS_SP1: prdata <= {{14{sp1_r[17]}}, sp1_r};
        OFS_SP2: prdata <= {{14{sp2_r[17]}}, sp2_r};
        OFS_SPLO: prdata <= {{14{splo_r[17]}}, splo_r};
        OFS_SPHI: prdata <= {{14{sphi_r[17]}}, sphi_r};
        OFS_YLVL: prdata <= {17'h0_0000, yrep_r, 1'b0, yman_r};
        OFS_CTRL: prdata <= {31'h0000_0000, key_man_r};
        OFS_CYC: prdata <= {16'h0000, cyc_r};
        OFS_STAT: prdata <= {26'h000_0000, meas_fault, lock_lv, sp2_active, tune_run,
          manual, out_on};
        OFS_PV: prdata <= {{24{y_out[7]}}, y_out};
        default: prdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Setpoint selection and clamping
  // ---------------------------------------------------------------
  assign sp_sel = (sp_as && sp_lv) ? sp2_r : sp1_r;
  always_comb
  begin
    sp_nxt = sp_sel;
    if (sp_nxt < splo_r)
      sp_nxt = splo_r;
    if (sp_nxt > sphi_r)
      sp_nxt = sphi_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_active <= '0;
      sp2_active <= 1'b0;
    end
    else
    begin
      sp_active <= sp_nxt;
      sp2_active <= sp_as && sp_lv;
    end
  end

  // ---------------------------------------------------------------
  // Manual / automatic
  // ---------------------------------------------------------------
  always_comb
  begin
    man_nxt = man_as ? man_lv : key_man_r;
    if (cfg_r.man_disable || lock_lv)
      man_nxt = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      manual <= 1'b0;
      man_d_r <= 1'b0;
      fault_d_r <= 1'b0;
    end
    else
    begin
      manual <= man_nxt;
      man_d_r <= manual;
      fault_d_r <= meas_fault;
    end
  end

  // ---------------------------------------------------------------
  // Output level
  // ---------------------------------------------------------------
  always_comb
  begin
    y_nxt = pid_level;
    if (cfg_r.func == FN_OFF)
      y_nxt = '0;
    else if (meas_fault)
      y_nxt = cfg_r.y_err_hold ? y_hold_r : $signed({1'b0, yrep_r});
    else if (manual)
      y_nxt = cfg_r.y_man_hold ? y_hold_r : $signed({1'b0, yman_r});
    else if (cfg_r.func == FN_THERMO)
    begin
      if (cfg_r.dir_direct)
        y_nxt = (actual > sp_active) ? $signed({1'b0, PCT_MAX}) : 8'sd0;
      else
        y_nxt = (actual < sp_active) ? $signed({1'b0, PCT_MAX}) : 8'sd0;
    end
    else
      y_nxt = cfg_r.dir_direct ? ((actual > sp_active) ? pid_level : 8'sd0)
        : ((actual < sp_active) ? pid_level : 8'sd0);
  end

  // Freeze last level at entry into manual or fault
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      y_hold_r <= '0;
    else if (!(manual && !man_d_r) && !(meas_fault && !fault_d_r) && !manual && !meas_fault)
      y_hold_r <= y_out;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      y_out <= '0;
      out_on <= 1'b0;
    end
    else
    begin
      y_out <= y_nxt;
      out_on <= (y_nxt > 8'sd0);
    end
  end

  // ---------------------------------------------------------------
  // Autotuning
  // ---------------------------------------------------------------
  assign tune_ok = cfg_r.tune_allow && !inh_lv && (cfg_r.func == FN_TWO_STATE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tune_run <= 1'b0;
      ss_d_r <= 1'b0;
      cyc_r <= CYC_DEF;
    end
    else
    begin
      ss_d_r <= ss_lv;
      if (!tune_ok)
        tune_run <= 1'b0;
      else if (ss_lv && !ss_d_r)
        tune_run <= !tune_run;
      else if (tune_done)
        tune_run <= 1'b0;
      if (tune_run && tune_done && cfg_r.accept_cyc)
        cyc_r <= (tune_cyc != 16'h0000) ? tune_cyc
          : (cfg_r.out_logic ? CYC_LOGIC : CYC_RELAY);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  mlock_a: assert property (@(posedge pclk) disable iff (!presetn)
    lock_lv |=> !manual) else $error("manual while locked");
  mdis_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_r.man_disable |=> !manual) else $error("manual while disabled");
  mlevel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (man_as && !cfg_r.man_disable && !lock_lv) |=> (manual == $past(man_lv)))
    else $error("manual not following input");
  sp_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sp_as && sp_lv) |=> sp2_active) else $error("setpoint 2 not selected");
  sp_lim_a: assert property (@(posedge pclk) disable iff (!presetn)
    (splo_r <= sphi_r) |=> (sp_active >= $past(splo_r) && sp_active <= $past(sphi_r)))
    else $error("setpoint outside limits");
  tune_inh_a: assert property (@(posedge pclk) disable iff (!presetn)
    (inh_lv || !cfg_r.tune_allow) |=> !tune_run) else $error("tuning not inhibited");
  tune_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tune_ok && ss_lv && !ss_d_r) |=> (tune_run != $past(tune_run)))
    else $error("edge did not toggle tuning");
  fault_rep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (meas_fault && !cfg_r.y_err_hold && cfg_r.func != FN_OFF)
    |=> (y_out == $signed({1'b0, $past(yrep_r)}))) else $error("fault level wrong");
  heat_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_r.func == FN_THERMO && !cfg_r.dir_direct && !meas_fault && !manual
    && actual < sp_active) |=> out_on) else $error("no heating output");
  off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_r.func == FN_OFF) |=> (y_out == 8'sd0)) else $error("output while off");
  cyc_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_r.accept_cyc |=> $stable(cyc_r)) else $error("cycle time changed");
endmodule // tsc_mode

// [verif/tsc_partner.sv]
// Partner model: digital input contacts and autotuning result source
`timescale 1ns/10ps
module tsc_partner
  import tsc_pkg::*;
#(
  parameter int N_DI = 7
)(
  input wire logic pclk,
  input wire logic [N_DI-1:0] di_set,
  input wire logic fin_req,
  input wire logic [15:0] cyc_val,
  output logic [N_DI-1:0] di,
  output logic tune_done,
  output logic [15:0] tune_cyc
);
  logic fin_d_r;
  initial
  begin
    di = '0;
    fin_d_r = 1'b0;
    tune_done = 1'b0;
    tune_cyc = '0;
  end
  // Contacts move just after the edge; result valid only with its pulse
  always @(posedge pclk)
  begin
    di <= di_set;
    fin_d_r <= fin_req;
    tune_done <= fin_req ^ fin_d_r;
    tune_cyc <= (fin_req ^ fin_d_r) ? cyc_val : ~cyc_val;
  end
endmodule // tsc_partner

// [verif/tsc_mode_tb.sv]
// Testbench: register access, mode, setpoint, manual, fault and tuning checks
`timescale 1ns/10ps
module tsc_mode_tb
  import tsc_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic meas_fault, fin_req, tune_done, out_on, tune_run, manual, sp2_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] di_set, di;
  logic signed [17:0] actual, sp_active;
  logic signed [7:0] pid_level, y_out;
  logic [15:0] cyc_val, tune_cyc;
  tsc_cfg_t c;
  int fails, checked;

  tsc_mode #(.N_DI(7)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .di(di), .actual(actual), .meas_fault(meas_fault),
    .pid_level(pid_level), .tune_done(tune_done), .tune_cyc(tune_cyc), .y_out(y_out),
    .out_on(out_on), .tune_run(tune_run), .manual(manual), .sp2_active(sp2_active),
    .sp_active(sp_active));
  tsc_partner #(.N_DI(7)) partner (.pclk(pclk), .di_set(di_set), .fin_req(fin_req),
    .cyc_val(cyc_val), .di(di), .tune_done(tune_done), .tune_cyc(tune_cyc));

  initial
  begin
    pclk = 1'b0;
  end
  always #4 pclk = ~pclk;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      $display("Error %s expected %h seen %h", n, x, g);
      fails++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic setc;
    wr(OFS_CFG, 32'(c));
  endtask

  // Contact to output level path is six cycles; allow margin
  task automatic st;
    repeat (8) @(posedge pclk);
  endtask

  task automatic tune(input logic [15:0] v, input logic [15:0] x);
    di_set <= 7'h08;
    st();
    di_set <= '0;
    cyc_val <= v;
    fin_req <= ~fin_req;
    st();
    chk("tune_end", '0, 32'(tune_run));
    apb(1'b0, OFS_CYC, '0);
    chk("cyc", 32'(x), q);
  endtask

  initial
  begin
    repeat (100000) @(posedge pclk);
    fails++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    di_set = '0;
    actual = '0;
    meas_fault = 1'b0;
    pid_level = '0;
    fin_req = 1'b0;
    cyc_val = '0;
    fails = 0;
    checked = 0;
    c = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("sp_rst", '0, 32'(sp_active));
    chk("man_rst", '0, 32'(manual));
    chk("tune_rst", '0, 32'(tune_run));
    apb(1'b0, OFS_CYC, '0);
    chk("cyc_rst", 32'(CYC_DEF), q);
    apb(1'b0, OFS_CFG, '0);
    chk("cfg_rst", 32'h0000_0151, q);
    apb(1'b0, 12'h028, '0);
    chk("bad_err", 32'h0000_0001, 32'(e));
    chk("bad_data", '0, q);
    c.func = FN_THERMO;
    setc();
    wr(OFS_SPHI, 32'h0000_07D0);
    wr(OFS_SP1, 32'h0000_1388);
    actual <= 18'sh0_01F4;
    st();
    chk("sp_clamp", 32'h0000_07D0, 32'(sp_active));
    chk("heat_on", 32'h0000_0001, 32'(out_on));
    actual <= 18'sh0_0BB8;
    st();
    chk("heat_off", '0, 32'(out_on));
    c.dir_direct = 1'b1;
    setc();
    st();
    chk("cool_on", 32'h0000_0001, 32'(out_on));
    c.func = FN_OFF;
    setc();
    st();
    chk("func_off", '0, 32'(out_on));
    c = '0;
    c.func = FN_THERMO;
    setc();
    wr(OFS_SP2, 32'h0000_012C);
    di_set <= 7'h7F;
    st();
    chk("sp2_none", '0, 32'(sp2_active));
    c.sel_sp = 3'd1;
    setc();
    st();
    chk("sp2_on", 32'h0000_0001, 32'(sp2_active));
    chk("sp2_val", 32'h0000_012C, 32'(sp_active));
    di_set <= '0;
    st();
    chk("sp1_val", 32'h0000_07D0, 32'(sp_active));
    c = '0;
    c.func = FN_TWO_STATE;
    c.sel_man = 3'd2;
    setc();
    wr(OFS_YLVL, 32'h0000_2846);
    pid_level <= 8'sh1E;
    actual <= 18'sh0_01F4;
    di_set <= 7'h02;
    st();
    chk("man_on", 32'h0000_0001, 32'(manual));
    chk("y_man", 32'h0000_0046, 32'(y_out));
    di_set <= '0;
    st();
    chk("man_off", '0, 32'(manual));
    chk("y_auto", 32'h0000_001E, 32'(y_out));
    c.y_man_hold = 1'b1;
    setc();
    di_set <= 7'h02;
    st();
    pid_level <= 8'sh32;
    st();
    chk("y_hold", 32'h0000_001E, 32'(y_out));
    c.sel_lock = 3'd3;
    setc();
    di_set <= 7'h06;
    st();
    chk("lock_exit", '0, 32'(manual));
    di_set <= 7'h04;
    st();
    di_set <= 7'h06;
    st();
    chk("lock_in", '0, 32'(manual));
    di_set <= 7'h02;
    st();
    chk("unlock", 32'h0000_0001, 32'(manual));
    c.man_disable = 1'b1;
    setc();
    st();
    chk("dis_sig", '0, 32'(manual));
    c.sel_man = SEL_NONE;
    c.sel_lock = SEL_NONE;
    setc();
    wr(OFS_CTRL, 32'h0000_0001);
    st();
    chk("dis_key", '0, 32'(manual));
    wr(OFS_CTRL, '0);
    c.man_disable = 1'b0;
    setc();
    wr(OFS_CTRL, 32'h0000_0001);
    st();
    chk("key_on", 32'h0000_0001, 32'(manual));
    wr(OFS_CTRL, '0);
    di_set <= '0;
    st();
    chk("key_off", '0, 32'(manual));
    meas_fault <= 1'b1;
    st();
    chk("y_repl", 32'h0000_0028, 32'(y_out));
    apb(1'b0, OFS_PV, '0);
    chk("pv_repl", 32'h0000_0028, q);
    meas_fault <= 1'b0;
    c.y_err_hold = 1'b1;
    setc();
    meas_fault <= 1'b1;
    st();
    pid_level <= 8'sh3C;
    st();
    chk("y_err_hold", 32'h0000_0032, 32'(y_out));
    meas_fault <= 1'b0;
    c = '0;
    c.func = FN_TWO_STATE;
    c.tune_allow = 1'b1;
    c.out_logic = 1'b1;
    c.accept_cyc = 1'b1;
    c.sel_tune_ss = 3'd4;
    setc();
    di_set <= 7'h08;
    st();
    chk("tune_go", 32'h0000_0001, 32'(tune_run));
    di_set <= '0;
    st();
    chk("tune_fall", 32'h0000_0001, 32'(tune_run));
    di_set <= 7'h08;
    st();
    chk("tune_stop", '0, 32'(tune_run));
    di_set <= '0;
    st();
    tune(16'h0000, CYC_LOGIC);
    c.accept_cyc = 1'b0;
    setc();
    tune(16'h0021, CYC_LOGIC);
    c.accept_cyc = 1'b1;
    setc();
    tune(16'h0021, 16'h0021);
    c.out_logic = 1'b0;
    setc();
    tune(16'h0000, CYC_RELAY);
    c.sel_tune_inh = 3'd5;
    setc();
    di_set <= 7'h18;
    st();
    chk("tune_inh", '0, 32'(tune_run));
    di_set <= '0;
    st();
    c.tune_allow = 1'b0;
    setc();
    di_set <= 7'h08;
    st();
    chk("tune_lock", '0, 32'(tune_run));
    end_sim();
  end
endmodule // tsc_mode_tb
